// file: verilog/calendar_pkg.sv
// Constants shared by the calendar clock unit and its wakeup timer.
// Assumes a single 40 MHz system clock and a 32-bit AHB-Lite register bus.
package calendar_pkg;

    // ------------------------------------------------------------------
    // Clocking
    // ------------------------------------------------------------------
    localparam int          CLK_HZ   = 40_000_000;
    localparam int          LS_HZ    = 32_768;
    // The 32.768 kHz base is made by a phase accumulator on ref_clk.
    localparam logic [25:0] ACC_MOD  = 26'(CLK_HZ);
    localparam logic [25:0] ACC_STEP = 26'(LS_HZ);
    // Low-speed ticks per full period of the 512 Hz reference.
    localparam int          CAL_HZ   = 512;
    localparam int          CAL_DIV  = LS_HZ / CAL_HZ;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_TIME   = 8'h00;
    localparam logic [7:0] OFF_DATE   = 8'h04;
    localparam logic [7:0] OFF_CTRL   = 8'h08;
    localparam logic [7:0] OFF_PRESC  = 8'h0c;
    localparam logic [7:0] OFF_SUBSEC = 8'h10;
    localparam logic [7:0] OFF_ALARM  = 8'h14;
    localparam logic [7:0] OFF_ALSS   = 8'h18;
    localparam logic [7:0] OFF_WKRLD  = 8'h1c;
    localparam logic [7:0] OFF_WKCNT  = 8'h20;
    localparam logic [7:0] OFF_STATUS = 8'h24;
    localparam logic [7:0] OFF_MASK   = 8'h28;
    localparam logic [7:0] OFF_BKP0   = 8'h2c;
    localparam int         NUM_BKP    = 5;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTL_H12   = 0;
    localparam int CTL_ALEN  = 1;
    localparam int CTL_WKEN  = 2;
    localparam int CTL_CALOE = 3;
    localparam int CTL_WKSEL = 4;
    localparam int TM_PM     = 22;
    localparam int AL_MSEC   = 7;
    localparam int AL_MMIN   = 15;
    localparam int AL_MHOUR  = 23;
    localparam int AL_WDSEL  = 30;
    localparam int AL_MDAY   = 31;
    localparam int ALSS_EN   = 31;
    localparam int ST_ALARM  = 0;
    localparam int ST_WAKE   = 1;
    localparam int PRE_A_LSB = 16;

    // ------------------------------------------------------------------
    // Reset values and the word transfer size
    // ------------------------------------------------------------------
    localparam logic [6:0]  PRE_A_RST = 7'h7f;
    localparam logic [14:0] PRE_S_RST = 15'h00ff;
    localparam logic [7:0]  BCD_ONE   = 8'h01;
    localparam logic [2:0]  HSIZE_WORD = 3'h2;

endpackage

// file: verilog/wakeup_timer.sv
// Auto-reload down counter that produces periodic wakeup events.
// Assumes lsTick and secTick are one-cycle pulses on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module wakeup_timer
    import calendar_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    input  wire logic             lsTick,
    input  wire logic             secTick,
    input  wire logic             enable,
    input  wire logic [2:0]       sel,
    input  wire logic [CNT_W-1:0] reload,
    output logic                  wkEvent,
    output logic [CNT_W:0]        count
);

    typedef struct packed {
        logic [3:0]   div;
        logic [CNT_W:0] cnt;
        logic         evt;
    } wk_state_t;

    wk_state_t   st_ff;
    wk_state_t   nxt_st;
    logic [3:0]  divMask;
    logic        tick;
    logic [CNT_W:0] full;

    // ------------------------------------------------------------------
    // Tick selection and counting
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.evt = 1'b0;
        // Selections 0 to 3 divide the low-speed base by 16, 8, 4 and 2.
        divMask = 4'hf >> sel[1:0];
        tick = sel[2] ? secTick
                      : (lsTick && ((st_ff.div & divMask) == divMask));
        // With both upper select bits set a 17th bit stretches the range.
        full = {(sel[2] && sel[1]), reload};
        if (lsTick) begin
            nxt_st.div = st_ff.div + 4'h1;
        end
        if (!enable) begin
            nxt_st.cnt = full;
            nxt_st.div = 4'h0;
        end else if (tick) begin
            if (st_ff.cnt == '0) begin
                nxt_st.evt = 1'b1;
                nxt_st.cnt = full;
            end else begin
                nxt_st.cnt = st_ff.cnt - 1'b1;
            end
        end
        if (sys_rst) begin
            nxt_st = '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        st_ff <= nxt_st;
    end

    assign wkEvent = st_ff.evt;
    assign count   = st_ff.cnt;

endmodule
`default_nettype wire

// file: verilog/calendar_clock_unit.sv
// Battery-domain calendar clock with alarm, wakeup timer and backup words.
// Assumes one AHB-Lite master, a 40 MHz ref_clk and synchronous inputs.
`timescale 1ns/1ps
`default_nettype none
module calendar_clock_unit
    import calendar_pkg::*;
#(
    parameter int BKP_WORDS = NUM_BKP,
    parameter int WK_W      = 16
) (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        lowPowerMode,
    output logic             irq,
    output logic             wakeReq,
    output logic             calOut
);

    typedef struct packed {
        logic [25:0]  acc;
        logic         lsTick;
        logic         secTick;
        logic [1:0]   chk;
        logic [6:0]   asyncCnt;
        logic [14:0]  syncCnt;
        logic [6:0]   preA;
        logic [14:0]  preS;
        logic [5:0]   calDiv;
        logic [6:0]   sec;
        logic [6:0]   min;
        logic [5:0]   hour;
        logic         pm;
        logic [2:0]   wday;
        logic [5:0]   date;
        logic [4:0]   mon;
        logic [7:0]   year;
        logic [7:0]   ctrl;
        logic [31:0]  alarm;
        logic [31:0]  alarmSs;
        logic [WK_W-1:0] wkReload;
        logic [1:0]   status;
        logic [1:0]   mask;
        logic [BKP_WORDS-1:0][31:0] bkp;
        logic         wrPend;
        logic         rdPend;
        logic [7:0]   addr;
        logic [31:0]  hrdata;
        logic         hready;
        logic         hresp;
        logic         irq;
        logic         wake;
        logic         calOut;
    } cal_state_t;

    cal_state_t   st_ff;
    cal_state_t   nxt_st;
    logic [25:0]  accSum;
    logic [31:0]  rdata;
    logic         accept;
    logic         wkEvent;
    logic [WK_W:0] wkCount;
    logic         dayAdv;
    logic         alMatch;
    logic [1:0]   events;
    logic [1:0]   clrBits;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] incBcd(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            return {v[7:4] + 4'h1, 4'h0};
        end
        return {v[7:4], v[3:0] + 4'h1};
    endfunction

    // Leap years are those divisible by four within the two-digit year.
    function automatic logic [5:0] lastDay(input logic [4:0] m,
                                           input logic [7:0] y);
        logic leap;
        leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                    : (y[3:0] == 4'h0 || y[3:0] == 4'h4 ||
                       y[3:0] == 4'h8);
        case (m)
            5'h02:   lastDay = leap ? 6'h29 : 6'h28;
            5'h04,
            5'h06,
            5'h09,
            5'h11:   lastDay = 6'h30;
            default: lastDay = 6'h31;
        endcase
    endfunction

    function automatic logic isBkp(input logic [7:0] a);
        return a >= OFF_BKP0 && a < OFF_BKP0 + 8'(4 * BKP_WORDS);
    endfunction

    function automatic logic [2:0] bkpIdx(input logic [7:0] a);
        logic [7:0] d;
        d = a - OFF_BKP0;
        return d[4:2];
    endfunction

    // ------------------------------------------------------------------
    // Wakeup counter
    // ------------------------------------------------------------------
    wakeup_timer #(
        .CNT_W (WK_W)
    ) i_wakeup_timer (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .lsTick  (st_ff.lsTick),
        .secTick (st_ff.secTick),
        .enable  (st_ff.ctrl[CTL_WKEN]),
        .sel     (st_ff.ctrl[CTL_WKSEL+:3]),
        .reload  (st_ff.wkReload),
        .wkEvent (wkEvent),
        .count   (wkCount)
    );

    // ------------------------------------------------------------------
    // Register read mux
    // ------------------------------------------------------------------
    always_comb begin
        rdata = 32'h0000_0000;
        case (st_ff.addr)
            OFF_TIME: begin
                rdata = {9'h000, st_ff.pm, st_ff.hour, 1'b0, st_ff.min,
                         1'b0, st_ff.sec};
            end
            OFF_DATE: begin
                rdata = {8'h00, st_ff.year, st_ff.wday, st_ff.mon,
                         2'h0, st_ff.date};
            end
            OFF_CTRL:   rdata = {24'h000000, st_ff.ctrl};
            OFF_PRESC:  rdata = {9'h000, st_ff.preA, 1'b0, st_ff.preS};
            OFF_SUBSEC: rdata = {17'h00000, st_ff.syncCnt};
            OFF_ALARM:  rdata = st_ff.alarm;
            OFF_ALSS:   rdata = st_ff.alarmSs;
            OFF_WKRLD:  rdata = 32'(st_ff.wkReload);
            OFF_WKCNT:  rdata = 32'(wkCount);
            OFF_STATUS: rdata = {30'h0, st_ff.status};
            OFF_MASK:   rdata = {30'h0, st_ff.mask};
            default: begin
                if (isBkp(st_ff.addr)) begin
                    rdata = st_ff.bkp[bkpIdx(st_ff.addr)];
                end
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Alarm compare
    // ------------------------------------------------------------------
    always_comb begin
        alMatch = st_ff.ctrl[CTL_ALEN];
        if (!st_ff.alarm[AL_MSEC] && st_ff.alarm[6:0] != st_ff.sec) begin
            alMatch = 1'b0;
        end
        if (!st_ff.alarm[AL_MMIN] && st_ff.alarm[14:8] != st_ff.min) begin
            alMatch = 1'b0;
        end
        if (!st_ff.alarm[AL_MHOUR] &&
            (st_ff.alarm[21:16] != st_ff.hour ||
             (st_ff.ctrl[CTL_H12] && st_ff.alarm[TM_PM] != st_ff.pm))) begin
            alMatch = 1'b0;
        end
        if (!st_ff.alarm[AL_MDAY]) begin
            if (st_ff.alarm[AL_WDSEL]) begin
                if (st_ff.alarm[26:24] != st_ff.wday) begin
                    alMatch = 1'b0;
                end
            end else if (st_ff.alarm[29:24] != st_ff.date) begin
                alMatch = 1'b0;
            end
        end
        // Compare two cycles after the sub-second step, once the calendar
        // holds the new second; one match gives one event, not a burst.
        if (!st_ff.chk[1] || st_ff.asyncCnt != st_ff.preA ||
            st_ff.syncCnt != (st_ff.alarmSs[ALSS_EN] ? st_ff.alarmSs[14:0]
                                                      : st_ff.preS)) begin
            alMatch = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        dayAdv = 1'b0;
        clrBits = 2'b00;
        nxt_st.lsTick = 1'b0;
        nxt_st.secTick = 1'b0;
        nxt_st.chk = {st_ff.chk[0], st_ff.lsTick};

        // The time base runs regardless of lowPowerMode.
        accSum = st_ff.acc + ACC_STEP;
        nxt_st.acc = accSum;
        if (accSum >= ACC_MOD) begin
            nxt_st.acc = accSum - ACC_MOD;
            nxt_st.lsTick = 1'b1;
        end

        if (st_ff.lsTick) begin
            nxt_st.calDiv = st_ff.calDiv + 6'h01;
            if (st_ff.asyncCnt == '0) begin
                nxt_st.asyncCnt = st_ff.preA;
                if (st_ff.syncCnt == '0) begin
                    nxt_st.syncCnt = st_ff.preS;
                    nxt_st.secTick = 1'b1;
                end else begin
                    nxt_st.syncCnt = st_ff.syncCnt - 15'h0001;
                end
            end else begin
                nxt_st.asyncCnt = st_ff.asyncCnt - 7'h01;
            end
        end
        // Bit 5 of the divider is a square wave of LS_HZ / 64.
        nxt_st.calOut = st_ff.ctrl[CTL_CALOE] &&
                        nxt_st.calDiv[$clog2(CAL_DIV)-1];

        // Calendar advance.
        if (st_ff.secTick) begin
            nxt_st.sec = 7'(incBcd({1'b0, st_ff.sec}));
            if (st_ff.sec == 7'h59) begin
                nxt_st.sec = 7'h00;
                nxt_st.min = 7'(incBcd({1'b0, st_ff.min}));
                if (st_ff.min == 7'h59) begin
                    nxt_st.min = 7'h00;
                    nxt_st.hour = 6'(incBcd({2'b00, st_ff.hour}));
                    if (st_ff.ctrl[CTL_H12]) begin
                        if (st_ff.hour == 6'h12) begin
                            nxt_st.hour = 6'h01;
                        end else if (st_ff.hour == 6'h11) begin
                            nxt_st.pm = !st_ff.pm;
                            dayAdv = st_ff.pm;
                        end
                    end else if (st_ff.hour == 6'h23) begin
                        nxt_st.hour = 6'h00;
                        dayAdv = 1'b1;
                    end
                end
            end
        end
        if (dayAdv) begin
            nxt_st.wday = (st_ff.wday == 3'h7) ? 3'h1 : st_ff.wday + 3'h1;
            nxt_st.date = 6'(incBcd({2'b00, st_ff.date}));
            if (st_ff.date == lastDay(st_ff.mon, st_ff.year)) begin
                nxt_st.date = 6'h01;
                nxt_st.mon = 5'(incBcd({3'b000, st_ff.mon}));
                if (st_ff.mon == 5'h12) begin
                    nxt_st.mon = 5'h01;
                    nxt_st.year = (st_ff.year == 8'h99) ? 8'h00
                                                        : incBcd(st_ff.year);
                end
            end
        end

        // Bus slave: writes land in the data phase, reads take one wait.
        accept = hsel && htrans[1] && hready && hsize == HSIZE_WORD;
        nxt_st.hready = 1'b1;
        nxt_st.hresp = 1'b0;
        nxt_st.wrPend = 1'b0;
        nxt_st.rdPend = 1'b0;
        if (st_ff.rdPend) begin
            nxt_st.hrdata = rdata;
        end
        if (st_ff.wrPend) begin
            case (st_ff.addr)
                OFF_TIME: begin
                    nxt_st.sec = hwdata[6:0];
                    nxt_st.min = hwdata[14:8];
                    nxt_st.hour = hwdata[21:16];
                    nxt_st.pm = hwdata[TM_PM];
                    // A new time starts a whole second.
                    nxt_st.asyncCnt = st_ff.preA;
                    nxt_st.syncCnt = st_ff.preS;
                end
                OFF_DATE: begin
                    nxt_st.date = hwdata[5:0];
                    nxt_st.mon = hwdata[12:8];
                    nxt_st.wday = hwdata[15:13];
                    nxt_st.year = hwdata[23:16];
                end
                OFF_CTRL:  nxt_st.ctrl = hwdata[7:0];
                OFF_PRESC: begin
                    nxt_st.preA = hwdata[PRE_A_LSB+:7];
                    nxt_st.preS = hwdata[14:0];
                end
                OFF_ALARM:  nxt_st.alarm = hwdata;
                OFF_ALSS:   nxt_st.alarmSs = hwdata;
                OFF_WKRLD:  nxt_st.wkReload = hwdata[WK_W-1:0];
                OFF_STATUS: clrBits = hwdata[1:0];
                OFF_MASK:   nxt_st.mask = hwdata[1:0];
                default: begin
                    if (isBkp(st_ff.addr)) begin
                        nxt_st.bkp[bkpIdx(st_ff.addr)] = hwdata;
                    end
                end
            endcase
        end
        if (accept) begin
            nxt_st.addr = {haddr[7:2], 2'b00};
            nxt_st.wrPend = hwrite;
            nxt_st.rdPend = !hwrite;
            nxt_st.hready = hwrite;
        end

        // Events: a set in the same cycle as a clear wins.
        events = 2'b00;
        events[ST_ALARM] = alMatch;
        events[ST_WAKE] = wkEvent;
        nxt_st.status = (st_ff.status & ~clrBits) | events;
        nxt_st.irq = |(nxt_st.status & nxt_st.mask);
        nxt_st.wake = lowPowerMode && (|nxt_st.status);

        if (sys_rst) begin
            nxt_st = '0;
            // Backup words ride through every reset.
            nxt_st.bkp = st_ff.bkp;
            nxt_st.preA = PRE_A_RST;
            nxt_st.preS = PRE_S_RST;
            nxt_st.asyncCnt = PRE_A_RST;
            nxt_st.syncCnt = PRE_S_RST;
            nxt_st.wday = BCD_ONE[2:0];
            nxt_st.date = BCD_ONE[5:0];
            nxt_st.mon = BCD_ONE[4:0];
            nxt_st.hready = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        st_ff <= nxt_st;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign hrdata    = st_ff.hrdata;
    assign hreadyout = st_ff.hready;
    assign hresp     = st_ff.hresp;
    assign irq       = st_ff.irq;
    assign wakeReq   = st_ff.wake;
    assign calOut    = st_ff.calOut;

endmodule
`default_nettype wire

// file: dv/calendar_checker.sv
// Checker for the calendar clock unit bus, interrupt and wake outputs.
// Assumes hready is fed back from hreadyout by the surrounding fabric.
`timescale 1ns/1ps
`default_nettype none
module calendar_checker (
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        lowPowerMode,
    input wire logic        irq,
    input wire logic        wakeReq,
    input wire logic        calOut
);
    logic take;
    logic wrPh_ff;

    assign take = hsel && htrans[1] && hready && hsize == 3'h2;

    // Marks the data phase of a write, when the register file changes.
    always_ff @(posedge ref_clk) begin
        wrPh_ff <= !sys_rst && take && hwrite;
    end

    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    a_resp_okay: assert property (!hresp)
        else $error("bus response is not OKAY");
    a_read_wait: assert property (take && !hwrite |=>
        !hreadyout ##1 hreadyout) else $error("read wait state wrong");
    a_write_nowait: assert property (take && hwrite |=>
        hreadyout [*2]) else $error("write was stalled");
    a_rst_quiet: assert property ($past(sys_rst) |->
        hreadyout && hrdata == 32'h0 && !irq && !wakeReq && !calOut)
        else $error("outputs not idle after reset");
    a_rdata_hold: assert property (
        hreadyout && $past(hreadyout) |-> $stable(hrdata))
        else $error("read data changed without a read");
    a_irq_clear: assert property ($fell(irq) |->
        $past(wrPh_ff) || $past(wrPh_ff, 2) || $past(wrPh_ff, 3))
        else $error("interrupt dropped without a write");
    a_wake_sleep: assert property (wakeReq |-> $past(lowPowerMode))
        else $error("wake request while awake");
    a_irq_wake: assert property (
        irq && lowPowerMode && !wrPh_ff && !$past(wrPh_ff) |=> wakeReq)
        else $error("pending event did not request wake");
    a_cal_slow: assert property ($changed(calOut) |=>
        !$changed(calOut) [*8]) else $error("reference toggles too fast");
endmodule

bind calendar_clock_unit calendar_checker i_calendar_checker (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .lowPowerMode(lowPowerMode), .irq(irq),
    .wakeReq(wakeReq), .calOut(calOut));
`default_nettype wire

// file: dv/tb_top.sv
// Self-checking bench for the calendar clock unit over AHB-Lite.
// Assumes one second is 1221 cycles once the prescaler is cleared.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import calendar_pkg::*;
;
    logic        ref_clk;
    logic        sys_rst;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic        lowPowerMode;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        irq;
    logic        wakeReq;
    logic        calOut;
    logic [31:0] rdq;
    logic [31:0] rnd;
    logic [31:0] bkp [NUM_BKP];
    logic [7:0]  alSec;
    int          wkRld;
    int          mismatches = 0;
    int          comparisons = 0;
    logic        calPrev;
    int          calCyc, calGap, calEdges;
    // Half period of the reference in ref_clk cycles, rounded down.
    localparam int CAL_T = CAL_DIV / 2 * CLK_HZ / LS_HZ;
    logic [31:0] dIn [6] = '{32'h00232228, 32'h00242228, 32'h00242229,
                             32'h00232430, 32'h00233231, 32'h0023e130};
    logic [31:0] dOut [6] = '{32'h00234301, 32'h00244229, 32'h00244301,
                              32'h00234501, 32'h00244101, 32'h00232131};

    calendar_clock_unit i_calendar_clock_unit (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(HSIZE_WORD),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .lowPowerMode(lowPowerMode),
        .irq(irq), .wakeReq(wakeReq), .calOut(calOut));

    always #12.5 ref_clk = ~ref_clk;

    // Times the gap between changes of the calibration output.
    always @(posedge ref_clk) begin
        calPrev <= calOut;
        if (!sys_rst && calOut !== calPrev) begin
            calGap <= calCyc;
            calCyc <= 1;
            calEdges <= calEdges + 1;
        end else begin
            calCyc <= calCyc + 1;
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] s,
                       input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic waitRdy();
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (n >= 20) begin
            mismatches++;
            end_sim();
        end
    endtask

    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        waitRdy();
        htrans <= 2'h0;
        hwdata <= d;
        waitRdy();
        rdq = hrdata;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input string nm);
        bus(a, 1'b0, 32'h0);
        chk(nm, rdq, e);
    endtask

    // Polls rather than waits a fixed time: tick spacing jitters by a cycle.
    task automatic waitChg(input logic [7:0] a, input logic [31:0] old);
        int n;
        n = 0;
        do begin
            bus(a, 1'b0, 32'h0);
            n++;
        end while (rdq === old && n < 1000);
        if (n >= 1000) begin
            mismatches++;
            end_sim();
        end
    endtask

    task automatic waitIrq(input int secs, input string nm);
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 9000) begin
            @(posedge ref_clk);
            n++;
        end
        chk(nm, 32'((n + 600) / 1221), 32'(secs));
    endtask

    initial begin
        ref_clk = 1'b0;
        sys_rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        lowPowerMode = 1'b0;
        rnd = 32'd53;
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        rd(OFF_TIME, 32'h0, "time");
        rd(OFF_DATE, 32'h00002101, "date");
        rd(OFF_PRESC, 32'h007f00ff, "presc");
        rd(OFF_SUBSEC, 32'(PRE_S_RST), "subsec");
        rd(OFF_CTRL, 32'h0, "ctrl");
        rd(8'hfc, 32'h0, "unmapped");
        $display("reset values test done");
        for (int i = 0; i < NUM_BKP; i++) begin
            rnd = lfsr(rnd);
            bkp[i] = rnd;
            bus(OFF_BKP0 + 8'(4 * i), 1'b1, rnd);
        end
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        for (int i = 0; i < NUM_BKP; i++) begin
            rd(OFF_BKP0 + 8'(4 * i), bkp[i], "backup");
        end
        $display("backup test done");
        bus(OFF_PRESC, 1'b1, 32'h0);
        for (int i = 0; i < 6; i++) begin
            bus(OFF_DATE, 1'b1, dIn[i]);
            bus(OFF_TIME, 1'b1, 32'h00235959);
            waitChg(OFF_DATE, dIn[i]);
            chk("date roll", rdq, dOut[i]);
        end
        rd(OFF_TIME, 32'h0, "midnight");
        bus(OFF_CTRL, 1'b1, 32'h9);
        bus(OFF_TIME, 1'b1, 32'h00115959);
        waitChg(OFF_TIME, 32'h00115959);
        chk("noon", rdq, 32'h00520000);
        $display("calendar test done");
        rnd = lfsr(rnd);
        alSec = 8'(rnd[1:0]) + 8'h2;
        bus(OFF_MASK, 1'b1, 32'h3);
        bus(OFF_CTRL, 1'b1, 32'ha);
        bus(OFF_ALARM, 1'b1, {24'h808030, alSec});
        bus(OFF_TIME, 1'b1, 32'h0);
        repeat (7000) @(posedge ref_clk);
        rd(OFF_STATUS, 32'h0, "no match");
        bus(OFF_ALARM, 1'b1, {24'h808080, alSec});
        bus(OFF_TIME, 1'b1, 32'h0);
        // Count from a second boundary; the first tick's phase is free.
        waitChg(OFF_TIME, 32'h0);
        waitIrq(int'(alSec) - 1, "alarm");
        rd(OFF_ALARM, {24'h808080, alSec}, "alarm word");
        bus(OFF_MASK, 1'b1, 32'h0);
        repeat (3) @(posedge ref_clk);
        chk("masked irq", {31'h0, irq}, 32'h0);
        rd(OFF_STATUS, 32'h1, "sticky");
        bus(OFF_STATUS, 1'b1, 32'h1);
        rd(OFF_STATUS, 32'h0, "cleared");
        $display("alarm test done");
        rnd = lfsr(rnd);
        wkRld = int'(rnd[1:0]) + 1;
        bus(OFF_WKRLD, 1'b1, 32'(wkRld));
        rd(OFF_WKCNT, 32'(wkRld), "wake count");
        bus(OFF_MASK, 1'b1, 32'h2);
        lowPowerMode <= 1'b1;
        bus(OFF_CTRL, 1'b1, 32'h4c);
        bus(OFF_TIME, 1'b1, 32'h0);
        waitChg(OFF_TIME, 32'h0);
        for (int k = 0; k < 2; k++) begin
            waitIrq(k == 0 ? wkRld : wkRld + 1, "wake period");
            repeat (2) @(posedge ref_clk);
            chk("wake req", {31'h0, wakeReq}, 32'h1);
            if (k == 0) begin
                rd(OFF_TIME, 32'(wkRld + 1), "asleep time");
            end
            bus(OFF_STATUS, 1'b1, 32'h2);
            repeat (2) @(posedge ref_clk);
        end
        lowPowerMode <= 1'b0;
        waitIrq(wkRld + 1, "reload");
        repeat (2) @(posedge ref_clk);
        chk("awake", {31'h0, wakeReq}, 32'h0);
        $display("wakeup test done");
        // The reference has run since the calendar test; one cycle of
        // jitter is allowed by the low-speed tick grid.
        for (int n = 0; calEdges < 2 && n < 60000; n++) begin
            @(posedge ref_clk);
        end
        chk("cal half", 32'((calGap - CAL_T) >> 1), 32'h0);
        $display("calibration test done");
        end_sim();
    end

    initial begin
        repeat (95000) @(posedge ref_clk);
        mismatches++;
        end_sim();
    end
endmodule
`default_nettype wire
